// File: inc/isrb_defs.vh
// What this block does
// R1 - Periodic timers 3 and 2 capture: PD4/PB2 and PD2/PB3 by select bit.
// R2 - Periodic timers 1 and 0 capture: PC4/PE3 and PC2/PF5 by select bit.
// R3 - Standard timers 2 and 1 capture: PD6/PF7 and PD0/PB6 by select bit.
// R4 - Standard timer 0 capture comes from PC6 or PE1 by select bit.
// R5 - Serial chip select comes from PA1 or PF0 by select bit.
// R6 - Serial data in from PA4/PF2, serial clock in from PA5/PF3.
// R7 - External interrupts 3 and 2 come from PA5/PC7 and PA4/PD0.
// R8 - External interrupts 1 and 0 come from PA3/PA7 and PA1/PA6.
// R9 - UART 1 receive from PD1/PF6, UART 0 receive from PA6/PD4.
// R10 - Unimplemented select bits read zero and ignore writes.
// R11 - Readback mode is on only while the key holds 11001010.
// R12 - With readback off, pins follow their selected function only.
// R13 - With readback on, a port read returns the real pin levels.
// R14 - Readback off: pin for inputs and I2C, latch or zero for outputs, zero analog.
// R15 - Readback off: analog path open only when its analog function is selected.
// R16 - Readback on: the selected analog channel path is forced on.
// R17 - Smallest variant has no selection register for upper timer inputs.
// R18 - Upper timer inputs come from port H at 0, alternate pin at 1.
// R19 - All select bits and the key clear to zero at reset.
`ifndef ISRB_DEFS_VH
`define ISRB_DEFS_VH

// Register byte offsets
`define ISRB_OFS_CAPTURE  8'h00
`define ISRB_OFS_SERIAL   8'h04
`define ISRB_OFS_UPPER    8'h08
`define ISRB_OFS_UART     8'h0C
`define ISRB_OFS_KEY      8'h10

// Implemented bits per register
`define ISRB_MASK_CAPTURE 8'h7F
`define ISRB_MASK_SERIAL  8'h7F
`define ISRB_MASK_UPPER   8'hFF
`define ISRB_MASK_UART    8'h03

// Reset values
`define ISRB_RST_SEL      8'h00
`define ISRB_RST_KEY      8'h00

// Readback unlock pattern
`define ISRB_KEY_UNLOCK   8'hCA

// Capture select field positions
`define ISRB_B_PT3_CAP    6
`define ISRB_B_PT2_CAP    5
`define ISRB_B_PT1_CAP    4
`define ISRB_B_PT0_CAP    3
`define ISRB_B_ST2_CAP    2
`define ISRB_B_ST1_CAP    1
`define ISRB_B_ST0_CAP    0

// Serial and interrupt select field positions
`define ISRB_B_CS         6
`define ISRB_B_SDI        5
`define ISRB_B_SCK        4
`define ISRB_B_IRQ3       3
`define ISRB_B_IRQ2       2
`define ISRB_B_IRQ1       1
`define ISRB_B_IRQ0       0

// Upper timer select fields: clocks at 7..4, captures at 3..0
`define ISRB_B_UP_CLK     4
`define ISRB_B_UP_CAP     0

// UART select field positions
`define ISRB_B_RX1        1
`define ISRB_B_RX0        0

`endif

// File: src/isrb_top.v
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "isrb_defs.vh"

module isrb_top #(
  parameter HAS_UPPER_SEL = 1
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Package pin levels
  input  wire [7:0]  pa_in,
  input  wire [7:0]  pb_in,
  input  wire [7:0]  pc_in,
  input  wire [7:0]  pd_in,
  input  wire [7:0]  pe_in,
  input  wire [7:0]  pf_in,
  input  wire [7:0]  pg_in,
  input  wire [7:0]  ph_in,
  input  wire [7:0]  pj_in,
  // Routed peripheral inputs
  output reg  [7:0]  ptimer_capture_input,
  output reg  [2:0]  stimer_capture_input,
  output reg  [7:4]  ptimer_clock_input,
  output reg         serial_chip_select,
  output reg         serial_data_in,
  output reg         serial_clock_in,
  output reg  [3:0]  ext_irq_in,
  output reg  [1:0]  uart_receive_in,
  // Port read request from the core
  input  wire        port_rd_req,
  input  wire [7:0]  port_rd_pin,
  input  wire [7:0]  port_rd_latch,
  input  wire [7:0]  port_direction_bit,
  input  wire [7:0]  port_rd_is_input,
  input  wire [7:0]  port_rd_is_i2c,
  input  wire [7:0]  port_rd_is_analog,
  output reg  [7:0]  port_rd_data,
  output reg         port_rd_valid,
  // Analog path control
  input  wire [3:0]  adc_chan_sel,
  input  wire [15:0] an_func_sel,
  output reg  [15:0] an_path_on,
  // Diagnostic state
  output reg         readback_mode_enable
);

  // Two-way source choice
  function pin_pick;
    input sel;
    input prim;
    input alt;
    begin
      pin_pick = sel ? alt : prim;
    end
  endfunction

  // Register address decode
  function [2:0] reg_index;
    input [7:0] addr;
    begin
      case (addr)
        `ISRB_OFS_CAPTURE: reg_index = 3'h0;
        `ISRB_OFS_SERIAL:  reg_index = 3'h1;
        `ISRB_OFS_UPPER:   reg_index = 3'h2;
        `ISRB_OFS_UART:    reg_index = 3'h3;
        `ISRB_OFS_KEY:     reg_index = 3'h4;
        default:           reg_index = 3'h7;
      endcase
    end
  endfunction

  reg  [7:0] capture_sel_r;
  reg  [7:0] serial_sel_r;
  reg  [7:0] upper_sel_r;
  reg  [7:0] uart_sel_r;
  reg  [7:0] key_r;
  reg  [7:0] rd_byte_nxt;
  reg  [7:0] port_rd_nxt;
  wire [7:0] upper_eff;
  wire [2:0] wr_idx;
  wire       wr_take;
  wire       key_open;
  wire [3:0] up_clk_prim;
  wire [3:0] up_clk_alt;
  wire [3:0] up_cap_prim;
  wire [3:0] up_cap_alt;
  wire [3:0] up_clk_nxt;
  wire [3:0] up_cap_nxt;
  wire [15:0] an_path_nxt;

  assign wr_idx  = reg_index(avs_address);
  assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];

  // R17 upper select absent
  assign upper_eff = (HAS_UPPER_SEL != 0) ? upper_sel_r : `ISRB_RST_SEL;

  // Read data mux
  always @*
  begin
    rd_byte_nxt = 8'h00;
    case (reg_index(avs_address))
      3'h0: rd_byte_nxt = capture_sel_r;
      3'h1: rd_byte_nxt = serial_sel_r;
      3'h2: rd_byte_nxt = upper_eff;
      3'h3: rd_byte_nxt = uart_sel_r;
      3'h4: rd_byte_nxt = key_r;
      default: rd_byte_nxt = 8'h00;
    endcase
  end

  // Bus handshake states
  localparam BUS_IDLE = 1'h0;
  localparam BUS_ACK  = 1'h1;

  reg        bus_state_r;
  reg        bus_state_nxt;

  // Next bus state: answer one cycle after a request is seen
  always @*
  begin
    bus_state_nxt = BUS_IDLE;
    case (bus_state_r)
      BUS_IDLE:
      begin
        if (avs_read || avs_write)
          bus_state_nxt = BUS_ACK;
      end
      BUS_ACK:
      begin
        bus_state_nxt = BUS_IDLE;
      end
      default:
      begin
        bus_state_nxt = BUS_IDLE;
      end
    endcase
  end

  // Bus handshake: one wait cycle, then accept
  always @(posedge clk)
  begin
    if (rst)
    begin
      bus_state_r     <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else
    begin
      bus_state_r     <= bus_state_nxt;
      avs_waitrequest <= (bus_state_nxt != BUS_ACK);
      if (bus_state_nxt == BUS_ACK)
        avs_readdata <= {24'h000000, rd_byte_nxt};
    end
  end

  // Register writes
  always @(posedge clk)
  begin
    // R19 reset to primary
    if (rst)
    begin
      capture_sel_r <= `ISRB_RST_SEL;
      serial_sel_r  <= `ISRB_RST_SEL;
      upper_sel_r   <= `ISRB_RST_SEL;
      uart_sel_r    <= `ISRB_RST_SEL;
      key_r         <= `ISRB_RST_KEY;
    end
    else if (wr_take)
    begin
      // R10 unimplemented bits masked
      case (wr_idx)
        3'h0: capture_sel_r <= avs_writedata[7:0] & `ISRB_MASK_CAPTURE;
        3'h1: serial_sel_r  <= avs_writedata[7:0] & `ISRB_MASK_SERIAL;
        3'h2: upper_sel_r   <= avs_writedata[7:0] & `ISRB_MASK_UPPER;
        3'h3: uart_sel_r    <= avs_writedata[7:0] & `ISRB_MASK_UART;
        3'h4: key_r         <= avs_writedata[7:0];
        default: key_r      <= key_r;
      endcase
    end
  end

  // R11 key compare
  assign key_open = (key_r == `ISRB_KEY_UNLOCK);

  always @(posedge clk)
  begin
    if (rst)
      readback_mode_enable <= 1'b0;
    else
      readback_mode_enable <= key_open;
  end

  // Timer captures, low-numbered and upper
  always @(posedge clk)
  begin
    if (rst)
    begin
      ptimer_capture_input      <= 8'h00;
      stimer_capture_input      <= 3'h0;
    end
    else
    begin
      // R1 periodic timers 3 and 2
      ptimer_capture_input[3] <= pin_pick(capture_sel_r[`ISRB_B_PT3_CAP], pd_in[4], pb_in[2]);
      ptimer_capture_input[2] <= pin_pick(capture_sel_r[`ISRB_B_PT2_CAP], pd_in[2], pb_in[3]);
      // R2 periodic timers 1 and 0
      ptimer_capture_input[1] <= pin_pick(capture_sel_r[`ISRB_B_PT1_CAP], pc_in[4], pe_in[3]);
      ptimer_capture_input[0] <= pin_pick(capture_sel_r[`ISRB_B_PT0_CAP], pc_in[2], pf_in[5]);
      // R3 standard timers 2 and 1
      stimer_capture_input[2] <= pin_pick(capture_sel_r[`ISRB_B_ST2_CAP], pd_in[6], pf_in[7]);
      stimer_capture_input[1] <= pin_pick(capture_sel_r[`ISRB_B_ST1_CAP], pd_in[0], pb_in[6]);
      // R4 standard timer 0
      stimer_capture_input[0] <= pin_pick(capture_sel_r[`ISRB_B_ST0_CAP], pc_in[6], pe_in[1]);
      // R18 upper timer captures
      ptimer_capture_input[7:4] <= up_cap_nxt;
    end
  end

  // Serial, interrupt and UART inputs
  always @(posedge clk)
  begin
    if (rst)
    begin
      serial_chip_select <= 1'b0;
      serial_data_in     <= 1'b0;
      serial_clock_in    <= 1'b0;
      ext_irq_in         <= 4'h0;
      uart_receive_in    <= 2'h0;
    end
    else
    begin
      // R5 chip select
      serial_chip_select <= pin_pick(serial_sel_r[`ISRB_B_CS], pa_in[1], pf_in[0]);
      // R6 shared serial pins
      serial_data_in     <= pin_pick(serial_sel_r[`ISRB_B_SDI], pa_in[4], pf_in[2]);
      serial_clock_in    <= pin_pick(serial_sel_r[`ISRB_B_SCK], pa_in[5], pf_in[3]);
      // R7 interrupts 3 and 2
      ext_irq_in[3]      <= pin_pick(serial_sel_r[`ISRB_B_IRQ3], pa_in[5], pc_in[7]);
      ext_irq_in[2]      <= pin_pick(serial_sel_r[`ISRB_B_IRQ2], pa_in[4], pd_in[0]);
      // R8 interrupts 1 and 0
      ext_irq_in[1]      <= pin_pick(serial_sel_r[`ISRB_B_IRQ1], pa_in[3], pa_in[7]);
      ext_irq_in[0]      <= pin_pick(serial_sel_r[`ISRB_B_IRQ0], pa_in[1], pa_in[6]);
      // R9 UART receive
      uart_receive_in[1] <= pin_pick(uart_sel_r[`ISRB_B_RX1], pd_in[1], pf_in[6]);
      uart_receive_in[0] <= pin_pick(uart_sel_r[`ISRB_B_RX0], pa_in[6], pd_in[4]);
    end
  end

  // Upper timer pin tables, index 0 is timer 4
  assign up_clk_prim = {ph_in[5], ph_in[4], ph_in[3], ph_in[2]};
  assign up_clk_alt  = {pj_in[4], pj_in[5], pj_in[6], pj_in[7]};
  assign up_cap_prim = {ph_in[7], ph_in[6], ph_in[1], ph_in[0]};
  assign up_cap_alt  = {pg_in[3], pg_in[2], pg_in[1], pg_in[0]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_upper
      // R18 upper timer routing
      assign up_clk_nxt[gi] = pin_pick(upper_eff[`ISRB_B_UP_CLK + gi],
                                       up_clk_prim[gi], up_clk_alt[gi]);
      assign up_cap_nxt[gi] = pin_pick(upper_eff[`ISRB_B_UP_CAP + gi],
                                       up_cap_prim[gi], up_cap_alt[gi]);
    end
  endgenerate

  always @(posedge clk)
  begin
    if (rst)
    begin
      ptimer_clock_input <= 4'h0;
    end
    else
    begin
      ptimer_clock_input <= up_clk_nxt;
    end
  end

  // Port read value per bit
  integer bi;
  always @*
  begin
    port_rd_nxt = 8'h00;
    for (bi = 0; bi < 8; bi = bi + 1)
    begin
      if (readback_mode_enable)
        // R13 raw pin levels
        port_rd_nxt[bi] = port_rd_pin[bi];
      else if (port_rd_is_analog[bi])
        // R14 analog reads zero
        port_rd_nxt[bi] = 1'b0;
      else if (port_rd_is_input[bi] || port_rd_is_i2c[bi])
        port_rd_nxt[bi] = port_rd_pin[bi];
      else
        // R12 function-defined output value
        port_rd_nxt[bi] = port_direction_bit[bi] ? 1'b0 : port_rd_latch[bi];
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      port_rd_data  <= 8'h00;
      port_rd_valid <= 1'b0;
    end
    else
    begin
      port_rd_valid <= port_rd_req;
      if (port_rd_req)
        port_rd_data <= port_rd_nxt;
    end
  end

  // Analog path switches
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_an
      // R15 R16 path gating
      assign an_path_nxt[gi] = an_func_sel[gi] ||
                               (readback_mode_enable &&
                                ({28'h0000000, adc_chan_sel} == gi));
    end
  endgenerate

  always @(posedge clk)
  begin
    if (rst)
      an_path_on <= 16'h0000;
    else
      an_path_on <= an_path_nxt;
  end

endmodule

// File: dv/isrb_assertions.sv
`timescale 1ns/1ps
module isrb_assertions (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Register bus
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Pins and routed inputs
  input wire [7:0]  pa_in,
  input wire [7:0]  pd_in,
  input wire [1:0]  uart_receive_in,
  // Port read
  input wire        port_rd_req,
  input wire [7:0]  port_rd_pin,
  input wire [7:0]  port_rd_latch,
  input wire [7:0]  port_direction_bit,
  input wire [7:0]  port_rd_is_input,
  input wire [7:0]  port_rd_is_i2c,
  input wire [7:0]  port_rd_is_analog,
  input wire [7:0]  port_rd_data,
  input wire        port_rd_valid,
  // Analog and mode
  input wire [3:0]  adc_chan_sel,
  input wire [15:0] an_func_sel,
  input wire [15:0] an_path_on,
  input wire        readback_mode_enable
);
  wire [7:0] dig_w = port_rd_is_input | port_rd_is_i2c;
  wire [7:0] nrm_w = (port_rd_pin & dig_w & ~port_rd_is_analog)
    | (port_rd_latch & ~port_direction_bit & ~(dig_w | port_rd_is_analog));
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  rd_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rd_valid_a: assert property (port_rd_valid == $past(port_rd_req))
    else $error("port read valid timing");
  rb_data_a: assert property (port_rd_req && readback_mode_enable |=>
    port_rd_data == $past(port_rd_pin)) else $error("readback data wrong");
  norm_data_a: assert property (port_rd_req && !readback_mode_enable |=>
    port_rd_data == $past(nrm_w)) else $error("normal port data wrong");
  an_off_a: assert property (!readback_mode_enable |=>
    an_path_on == $past(an_func_sel)) else $error("analog path wrong");
  an_force_a: assert property (readback_mode_enable |=>
    an_path_on == ($past(an_func_sel) | (16'h1 << $past(adc_chan_sel))))
    else $error("analog path not forced");
  rst_clear_a: assert property ($past(rst) |-> avs_waitrequest && !readback_mode_enable)
    else $error("reset state wrong");
  uart_route_a: assert property (!$past(rst) |-> uart_receive_in[0] == $past(pa_in[6])
    || uart_receive_in[0] == $past(pd_in[4])) else $error("uart 0 route wrong");
  cover property (port_rd_req && readback_mode_enable);
  cover property (!avs_waitrequest && avs_write);
  cover property ($rose(readback_mode_enable));
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         clk, rst, avs_read, avs_write, port_rd_req;
  reg  [7:0]  avs_address, pa_in, pb_in, pc_in, pd_in, pe_in, pf_in, pg_in, ph_in, pj_in;
  reg  [31:0] avs_writedata, seed, q;
  reg  [3:0]  avs_byteenable, adc_chan_sel;
  reg  [7:0]  port_rd_pin, port_rd_latch, port_direction_bit;
  reg  [7:0]  port_rd_is_input, port_rd_is_i2c, port_rd_is_analog;
  reg  [15:0] an_func_sel;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, serial_chip_select, serial_data_in, serial_clock_in;
  wire        port_rd_valid, readback_mode_enable;
  wire [7:0]  ptimer_capture_input, port_rd_data;
  wire [2:0]  stimer_capture_input;
  wire [7:4]  ptimer_clock_input;
  wire [3:0]  ext_irq_in;
  wire [1:0]  uart_receive_in;
  wire [15:0] an_path_on;
  reg  [7:0]  sel [0:4];
  integer     mismatches, n_checks, i, j;
  localparam logic [7:0] MSK [5] = '{8'h7F, 8'h7F, 8'hFF, 8'h03, 8'hFF};
  isrb_top isrb_top_i (.*);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task results;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    integer k;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (k == 20)
    begin
      mismatches++;
      results;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    bus(1, a, d);
    if (avs_byteenable[0] && a < 8'h14)
      sel[a >> 2] = d & MSK[a >> 2];
  endtask
  task rdc(input [7:0] a);
    bus(0, a, 0);
    chk(q, a < 8'h14 ? sel[a >> 2] : 0);
  endtask
  task rt;
    reg [7:0] s0, s1, s2, s3;
    s0 = sel[0];
    s1 = sel[1];
    s2 = sel[2];
    s3 = sel[3];
    @(posedge clk);
    {pa_in, pb_in, pc_in, pd_in} <= {rnd(), rnd()};
    {pe_in, pf_in, pg_in, ph_in} <= rnd();
    pj_in <= rnd();
    {adc_chan_sel, an_func_sel} <= rnd();
    repeat (2) @(posedge clk);
    chk({ptimer_capture_input[3:0], stimer_capture_input, serial_chip_select, serial_data_in,
      serial_clock_in, ext_irq_in, uart_receive_in}, {s0[6] ? pb_in[2] : pd_in[4],
      s0[5] ? pb_in[3] : pd_in[2], s0[4] ? pe_in[3] : pc_in[4], s0[3] ? pf_in[5] : pc_in[2],
      s0[2] ? pf_in[7] : pd_in[6], s0[1] ? pb_in[6] : pd_in[0], s0[0] ? pe_in[1] : pc_in[6],
      s1[6] ? pf_in[0] : pa_in[1], s1[5] ? pf_in[2] : pa_in[4], s1[4] ? pf_in[3] : pa_in[5],
      s1[3] ? pc_in[7] : pa_in[5], s1[2] ? pd_in[0] : pa_in[4], s1[1] ? pa_in[7] : pa_in[3],
      s1[0] ? pa_in[6] : pa_in[1], s3[1] ? pf_in[6] : pd_in[1],
      s3[0] ? pd_in[4] : pa_in[6]});
    chk({ptimer_clock_input, ptimer_capture_input[7:4]}, {s2[7] ? pj_in[4] : ph_in[5],
      s2[6] ? pj_in[5] : ph_in[4], s2[5] ? pj_in[6] : ph_in[3], s2[4] ? pj_in[7] : ph_in[2],
      s2[3] ? pg_in[3] : ph_in[7], s2[2] ? pg_in[2] : ph_in[6], s2[1] ? pg_in[1] : ph_in[1],
      s2[0] ? pg_in[0] : ph_in[0]});
    chk(an_path_on, an_func_sel | (sel[4] == 8'hCA ? 16'h1 << adc_chan_sel : 0));
  endtask
  task pr;
    reg [31:0] t;
    reg [7:0]  e;
    t = rnd();
    @(posedge clk);
    port_rd_req <= 1;
    {port_rd_pin, port_rd_latch, port_direction_bit} <= rnd();
    port_rd_is_input <= t[7:0];
    port_rd_is_i2c <= ~t[7:0] & t[15:8];
    port_rd_is_analog <= ~t[7:0] & ~t[15:8] & t[23:16];
    @(posedge clk);
    port_rd_req <= 0;
    e = (port_rd_pin & (port_rd_is_input | port_rd_is_i2c)) | (port_rd_latch
      & ~port_direction_bit & ~(port_rd_is_input | port_rd_is_i2c | port_rd_is_analog));
    @(posedge clk);
    chk(port_rd_valid, 1);
    chk(port_rd_data, sel[4] == 8'hCA ? port_rd_pin : e);
  endtask
  initial
  begin
    rst = 1;
    {avs_read, avs_write, port_rd_req, avs_address, avs_writedata} = 0;
    {pa_in, pb_in, pc_in, pd_in, pe_in, pf_in, pg_in, ph_in, pj_in} = 0;
    {port_rd_pin, port_rd_latch, port_direction_bit} = 0;
    {port_rd_is_input, port_rd_is_i2c, port_rd_is_analog, adc_chan_sel, an_func_sel} = 0;
    avs_byteenable = 4'hF;
    seed = 32'h81bbbb8d;
    mismatches = 0;
    n_checks = 0;
    for (i = 0; i < 5; i++)
      sel[i] = 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 6; i++)
      rdc(8'(i * 4));
    for (j = 0; j < 12; j++)
    begin
      avs_byteenable <= (j == 5) ? 4'hE : 4'hF;
      for (i = 0; i < 5; i++)
        wr(8'(i * 4), (i == 4 && j % 3 == 0) ? 8'hCA : 8'(rnd()));
      wr(8'h14, 8'(rnd()));
      for (i = 0; i < 6; i++)
        rdc(8'(i * 4));
      chk(readback_mode_enable, sel[4] == 8'hCA);
      rt;
      pr;
    end
    results;
  end
endmodule
bind isrb_top isrb_assertions isrb_assertions_i (.*);
